// File: common/amps_pkg.sv
// constants for the analog probe mux control
package amps_pkg;
    // ****************************************
    // select codes
    // ****************************************
    localparam int SEL_W = 5;
    localparam int CH_N = 32;
    localparam logic [4:0] SEL_HIZ = 5'h00;
    localparam logic [4:0] SEL_INPUT_SUPPLY = 5'h01;
    localparam logic [4:0] SEL_STBY_ONE = 5'h02;
    localparam logic [4:0] SEL_STBY_TWO = 5'h03;
    localparam logic [4:0] SEL_BUCK_FB_FIRST = 5'h04;
    localparam logic [4:0] SEL_BUCK_FB_LAST = 5'h08;
    localparam logic [4:0] SEL_LIN_ONE = 5'h0b;
    localparam logic [4:0] SEL_LIN_TWO = 5'h0c;
    localparam logic [4:0] SEL_DIE_TEMP = 5'h0f;
    localparam logic [4:0] SEL_BUCK_TEMP_FIRST = 5'h10;
    localparam logic [4:0] SEL_BUCK_TEMP_LAST = 5'h14;
    localparam logic [4:0] SEL_LIN_TEMP = 5'h17;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] SWITCH_RST = 32'h0000_0000;
    localparam logic PULLDOWN_RST = 1'b1;
endpackage : amps_pkg

// File: common/amps_sel_if.sv
// select and decode signals between the control and the decoder
`timescale 1ns/100ps
`default_nettype none
interface amps_sel_if;
    logic [4:0] code;
    logic [31:0] onehot;
    logic valid;
    modport ctrl (output code, input onehot, input valid);
    modport dec (input code, output onehot, output valid);
endinterface : amps_sel_if
`default_nettype wire

// File: rtl/amps_decode.sv
// decoder from select code to one-hot channel switch
`timescale 1ns/100ps
`default_nettype none
module amps_decode
(
    // select link
    amps_sel_if.dec sel
);
    // ****************************************
    // per-code decode
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < amps_pkg::CH_N; i++)
        begin : g_ch
            localparam logic [4:0] C = 5'(i);
            assign sel.onehot[i] = (sel.code == C) && (
                (C >= amps_pkg::SEL_INPUT_SUPPLY && C <= amps_pkg::SEL_STBY_TWO) ||
                (C >= amps_pkg::SEL_BUCK_FB_FIRST && C <= amps_pkg::SEL_BUCK_FB_LAST) ||
                C == amps_pkg::SEL_LIN_ONE || C == amps_pkg::SEL_LIN_TWO ||
                C == amps_pkg::SEL_DIE_TEMP || C == amps_pkg::SEL_LIN_TEMP ||
                (C >= amps_pkg::SEL_BUCK_TEMP_FIRST && C <= amps_pkg::SEL_BUCK_TEMP_LAST));
        end
    endgenerate
    // reserved and zero codes close nothing
    assign sel.valid = |sel.onehot;
endmodule : amps_decode
`default_nettype wire

// File: rtl/amps_top.sv
// control of the analog probe output mux
`timescale 1ns/100ps
`default_nettype none
// Operation
// - disabled: all switches open, pull-down on
// - enabled: route the selected channel
// - enabled code zero: open, no pull-down
// - codes 1-3 supplies, 4-8 buck feedbacks
// - codes 0b,0c linear regulator outputs
// - codes 0f,10-14,17 temperature sensors
// - route only in system-on states
// - sensor probing never touches thermal handling
module amps_top
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // control
    input wire logic analog_mux_enable_in,
    input wire logic [4:0] probe_channel_select_in,
    input wire logic system_on_in,
    // analog switch drive
    output logic [31:0] channel_switch_out,
    output logic pulldown_out
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic rstn;

    // async assert, release two edges later
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rstn = rst_sync_q[1];

    // ****************************************
    // decode
    // ****************************************
    amps_sel_if sel ();

    assign sel.code = probe_channel_select_in;

    amps_decode u_dec
    (
        .sel(sel)
    );

    // ****************************************
    // channel groups
    // ****************************************
    typedef enum logic [2:0] {
        GRP_NONE = 3'h0,
        GRP_SUPPLY = 3'h1,
        GRP_BUCK_FB = 3'h2,
        GRP_LIN_REG = 3'h3,
        GRP_TEMP = 3'h4
    } amps_group_t;

    amps_group_t grp;

    // second, independent look at the code
    always_comb
    begin
        grp = GRP_NONE;
        unique case (sel.code) inside
            [amps_pkg::SEL_INPUT_SUPPLY : amps_pkg::SEL_STBY_TWO]:
            begin
                grp = GRP_SUPPLY;
            end
            [amps_pkg::SEL_BUCK_FB_FIRST : amps_pkg::SEL_BUCK_FB_LAST]:
            begin
                grp = GRP_BUCK_FB;
            end
            amps_pkg::SEL_LIN_ONE:
            begin
                grp = GRP_LIN_REG;
            end
            amps_pkg::SEL_LIN_TWO:
            begin
                grp = GRP_LIN_REG;
            end
            amps_pkg::SEL_DIE_TEMP:
            begin
                grp = GRP_TEMP;
            end
            [amps_pkg::SEL_BUCK_TEMP_FIRST : amps_pkg::SEL_BUCK_TEMP_LAST]:
            begin
                grp = GRP_TEMP;
            end
            amps_pkg::SEL_LIN_TEMP:
            begin
                grp = GRP_TEMP;
            end
            default:
            begin
                // zero and reserved codes
                grp = GRP_NONE;
            end
        endcase
    end

    // ****************************************
    // route permission
    // ****************************************
    logic grp_known;
    logic route_ok;

    assign grp_known = (grp != GRP_NONE);

    // both decode paths must agree before a switch closes
    assign route_ok = system_on_in && grp_known && sel.valid;

    // ****************************************
    // pin mode
    // ****************************************
    typedef enum logic [1:0] {
        PIN_PULLDOWN = 2'h0,
        PIN_HIZ = 2'h1,
        PIN_ROUTE = 2'h2
    } amps_pin_t;

    amps_pin_t pin_mode;

    always_comb
    begin
        pin_mode = PIN_PULLDOWN;
        if (!analog_mux_enable_in)
        begin
            pin_mode = PIN_PULLDOWN;
        end
        else if (route_ok)
        begin
            pin_mode = PIN_ROUTE;
        end
        else
        begin
            pin_mode = PIN_HIZ;
        end
    end

    // ****************************************
    // switch gating
    // ****************************************
    wire logic [31:0] sw_gate;

    // one switch per code
    genvar ch;
    generate
        for (ch = 0; ch < amps_pkg::CH_N; ch++)
        begin : g_gate
            assign sw_gate[ch] = (pin_mode == PIN_ROUTE) && sel.onehot[ch];
        end
    endgenerate

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] sw;
        logic pd;
    } amps_state_t;

    amps_state_t st_q;
    amps_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        unique case (pin_mode)
            PIN_PULLDOWN:
            begin
                st_d.sw = 32'h0;
                st_d.pd = 1'b1;
            end
            PIN_HIZ:
            begin
                st_d.sw = 32'h0;
                st_d.pd = 1'b0;
            end
            PIN_ROUTE:
            begin
                // sensor taps are read-only, thermal path untouched
                st_d.sw = sw_gate;
                st_d.pd = 1'b0;
            end
            default:
            begin
                // unused mode code, fall back to pull-down
                st_d.sw = 32'h0;
                st_d.pd = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q.sw <= amps_pkg::SWITCH_RST;
            st_q.pd <= amps_pkg::PULLDOWN_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign channel_switch_out = st_q.sw;
    assign pulldown_out = st_q.pd;
endmodule : amps_top
`default_nettype wire

// File: tb/amps_probe_model.sv
// probe pin reader
`timescale 1ns/100ps
`default_nettype none
module amps_probe_model
(
    input wire logic [31:0] switch_in,
    input wire logic pulldown_in,
    output logic fault_out
);
    assign fault_out = $countones(switch_in) > 1 || pulldown_in && |switch_in;
endmodule : amps_probe_model
`default_nettype wire

// File: tb/amps_top_asserts.sv
// port checker
`timescale 1ns/100ps
`default_nettype none
module amps_top_asserts
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic analog_mux_enable_in,
    input wire logic [4:0] probe_channel_select_in,
    input wire logic system_on_in,
    input wire logic [31:0] channel_switch_out,
    input wire logic pulldown_out
);
    logic [1:0] u_q;
    wire logic e = analog_mux_enable_in;
    wire logic g = e && system_on_in;
    wire logic [4:0] s = probe_channel_select_in;
    wire logic [31:0] w = channel_switch_out;
    wire logic [31:0] h = 32'h1 << s;
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            u_q <= 2'h0;
        end
        else if (u_q != 2'h3)
        begin
            u_q <= u_q + 2'h1;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in || u_q != 2'h3);
    a_off_pd: assert property (!e |=> !w && pulldown_out) else $error("off");
    a_on_one: assert property (e |=> !pulldown_out && $onehot0(w)) else $error("one");
    a_zero_hiz: assert property (e && !s |=> !w) else $error("hiz");
    a_supply_fb: assert property (g && s inside {[1:8]} |=> w == $past(h)) else $error("sup");
    a_lin_reg: assert property (g && s inside {11, 12} |=> w == $past(h)) else $error("lin");
    a_temp_sense: assert property (g && s inside {[15:20], 23} |=> w == $past(h)) else $error("tmp");
    a_sys_off: assert property (!system_on_in |=> !w) else $error("sys");
    a_resv_open: assert property (e && s inside {9, 10, 13, 14, 21, 22, [24:31]} |=> !w) else $error("rsv");
endmodule : amps_top_asserts
bind amps_top amps_top_asserts chk_u
(
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .analog_mux_enable_in(analog_mux_enable_in),
    .probe_channel_select_in(probe_channel_select_in),
    .system_on_in(system_on_in),
    .channel_switch_out(channel_switch_out),
    .pulldown_out(pulldown_out)
);
`default_nettype wire

// File: tb/tb_top.sv
// bench
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic c = 1'b0, r = 1'b0, e = 1'b0, o = 1'b0, f, p;
    logic [4:0] s = 5'h00;
    logic [31:0] w, x = 32'hdaab;
    logic [32:0] exp_q[$];
    int fail_count = 0, n_checks = 0, t = 0;
    amps_top dut_u (.clock_in(c), .rstn_in(r), .analog_mux_enable_in(e), .probe_channel_select_in(s),
        .system_on_in(o), .channel_switch_out(w), .pulldown_out(p));
    amps_probe_model pm_u (.switch_in(w), .pulldown_in(p), .fault_out(f));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [32:0] pin_model(input logic en, input logic on, input logic [4:0] code);
        if (!en)
            return 33'h1_0000_0000;
        if (on && code inside {[1:8], 11, 12, [15:20], 23})
            return {1'b0, 32'h1 << code};
        return 33'h0;
    endfunction : pin_model
    task automatic cmp_pin(input logic [32:0] g, input logic [32:0] d);
        n_checks++;
        if (g !== d)
        begin
            fail_count++;
            $display("MISMATCH %0t %h %h", $time, g, d);
        end
    endtask : cmp_pin
    task automatic cmp_fault(input logic g, input logic d);
        n_checks++;
        if (g !== d)
        begin
            fail_count++;
            $display("MISMATCH %0t %h %h", $time, g, d);
        end
    endtask : cmp_fault
    task automatic finish_test;
        if (t > 400)
            fail_count++;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
        forever #12.5 c = ~c;
    always @(posedge c)
        if (++t > 400)
            finish_test;
    initial
    begin
        repeat (3) @(posedge c);
        #1;
        cmp_pin({p, w}, 33'h1_0000_0000);
        @(posedge c);
        r <= 1'b1;
        repeat (3) @(posedge c);
        for (int i = 0; i < 300; i++)
        begin
            x = lfsr_next(x);
            @(posedge c);
            e <= i < 32 || x[0];
            o <= i < 32 || x[1];
            s <= i < 32 ? i[4:0] : x[6:2];
            #1;
            if (i > 0)
                cmp_pin({p, w}, exp_q.pop_front());
            cmp_fault(f, 1'b0);
            exp_q.push_back(pin_model(e, o, s));
        end
        finish_test;
    end
endmodule : tb_top
`default_nettype wire
